// >>> src/dpsm_pkg.sv
package dpsm_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam int PADDR_W = 18;
    localparam logic [15:0] IDX_CMD = 16'h6040;
    localparam logic [15:0] IDX_STAT = 16'h6041;
    localparam logic [15:0] IDX_QSC = 16'h605A;
    localparam logic [15:0] IDX_SDC = 16'h605B;
    localparam logic [15:0] IDX_MODE = 16'h6060;
    localparam logic [15:0] IDX_MACT = 16'h6061;
    localparam logic [15:0] IDX_HOLD = 16'h3212;
    localparam logic [15:0] IDX_IST = 16'h7000;
    localparam logic [15:0] IDX_IMSK = 16'h7001;
    localparam logic [15:0] IDX_CFG = 16'h7002;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------
    // Command word bits
    // ------------------------------------------------------------
    localparam int CB_SO = 0;
    localparam int CB_EV = 1;
    localparam int CB_QS = 2;
    localparam int CB_EO = 3;
    localparam int CB_FR = 7;

    // ------------------------------------------------------------
    // State word bits
    // ------------------------------------------------------------
    localparam int SB_RTSO = 0;
    localparam int SB_SWON = 1;
    localparam int SB_OPEN = 2;
    localparam int SB_FLT = 3;
    localparam int SB_VOLT = 4;
    localparam int SB_QS = 5;
    localparam int SB_SOD = 6;
    localparam int SB_IDX = 15;

    // ------------------------------------------------------------
    // Reaction codes and configuration
    // ------------------------------------------------------------
    localparam logic [15:0] RC_IMM = 16'h0000;
    localparam logic [15:0] RC_SLOW = 16'h0001;
    localparam logic [15:0] RC_QUICK = 16'h0002;
    localparam logic [7:0] HOLD_ON = 8'h01;
    localparam int CFG_CLOSED = 0;
    localparam int CFG_ENCCOM = 1;
    localparam int CFG_W = 2;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_STATE = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_INDEX = 2;
    localparam int IRQ_MODEREJ = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CMD = 16'h0000;
    localparam logic [15:0] RST_CODE = 16'h0000;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_HOLD = 8'h00;
    localparam logic [CFG_W-1:0] RST_CFG = 2'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_NRDY = 4'b0000,
        ST_SOD = 4'b0001,
        ST_RTSO = 4'b0011,
        ST_SWON = 4'b0010,
        ST_OPEN = 4'b0110,
        ST_QSA = 4'b0111,
        ST_FRA = 4'b0101,
        ST_FLT = 4'b0100,
        ST_DEAD = 4'b1100
    } dpsm_state_t;

endpackage : dpsm_pkg

// >>> src/dpsm_edge.sv
`timescale 1ns/1ps
module dpsm_edge
    import dpsm_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic din, // Level to watch
    output logic rise // High in cycle din is 1 after 0
);

    typedef struct packed {
        logic prev;
    } dpsm_edge_s_t;

    dpsm_edge_s_t s_r;
    dpsm_edge_s_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = din;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // A level held high yields a single pulse only
    assign rise = din & ~s_r.prev;

endmodule : dpsm_edge

// >>> src/dpsm_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Decode shutdown, switch on, enable operation commands
// - Disable voltage and quick stop override the other bits, except fault reset (bit 7) which blocks them
// - State word encodes the five normal states
// - State word encodes quick stop and fault states
// - After self-test, settle in switch on disabled
// - Requested mode becomes active at operation enabled
// - Mode writes accepted only in three idle states
// - Unrecoverable error locks in not ready forever
// - Holding torque in switched on when configured
// - Quick stop applies its programmed stop reaction
// - Shutdown from operation applies shutdown reaction
// - State bit 15 flags encoder index seen in closed loop with encoder commutation
module dpsm_top
    import dpsm_pkg::*;
(
    input wire logic clk, // Clock, 50 MHz
    input wire logic rst, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [PADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic selftest_ok, // Power-on self-test passed
    input wire logic fatal_err, // Unrecoverable error
    input wire logic fault_in, // Recoverable fault occurred
    input wire logic ramp_done, // Motion control finished braking
    input wire logic encoder_index, // Encoder index pulse
    output logic stop_now, // Immediate stop pulse
    output logic brake_slow, // Brake on slow-down ramp
    output logic brake_quick, // Brake on quick-stop ramp
    output logic power_en, // Power stage energised
    output logic hold_torque, // Hold motor in switched on
    output logic [7:0] active_mode, // Operating mode in effect
    output logic irq // Level interrupt
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dpsm_state_t st;
        logic [15:0] cmd;
        logic [15:0] qs_code;
        logic [15:0] sd_code;
        logic [7:0] mode_req;
        logic [7:0] mode_act;
        logic [7:0] hold_cfg;
        logic [CFG_W-1:0] cfg;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic index_seen;
        logic brake_slow;
        logic brake_quick;
        logic stop_now;
        logic [31:0] rdata;
        logic slverr;
    } dpsm_s_t;

    dpsm_s_t s_r;
    dpsm_s_t s_nxt;

    logic fault_rise, cmd_ok, do_dis_volt, do_quick, do_shutdown, do_switch_on, do_enable;
    logic setup_ph, access_ph, aligned, hit, mode_ok;
    logic [15:0] state_word, idx;
    logic [31:0] rd_val;

    dpsm_edge u_fault_edge (.clk(clk), .rst(rst), .din(s_r.cmd[CB_FR]), .rise(fault_rise));

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    always_comb begin
        cmd_ok = ~s_r.cmd[CB_FR];
        do_dis_volt = cmd_ok & ~s_r.cmd[CB_EV];
        do_quick = cmd_ok & s_r.cmd[CB_EV] & ~s_r.cmd[CB_QS];
        do_shutdown = cmd_ok & s_r.cmd[CB_QS] & s_r.cmd[CB_EV] & ~s_r.cmd[CB_SO];
        do_switch_on = cmd_ok & ~s_r.cmd[CB_EO] & s_r.cmd[CB_QS] & s_r.cmd[CB_EV]
                       & s_r.cmd[CB_SO];
        do_enable = cmd_ok & s_r.cmd[CB_EO] & s_r.cmd[CB_QS] & s_r.cmd[CB_EV]
                    & s_r.cmd[CB_SO];
    end

    // ------------------------------------------------------------
    // State word
    // ------------------------------------------------------------
    always_comb begin
        state_word = '0;
        state_word[SB_QS] = (s_r.st != ST_QSA);
        state_word[SB_VOLT] = power_en;
        unique case (s_r.st)
            ST_NRDY, ST_DEAD: state_word[SB_QS] = 1'b0;
            ST_SOD: state_word[SB_SOD] = 1'b1;
            ST_RTSO: state_word[SB_RTSO] = 1'b1;
            ST_SWON: begin
                state_word[SB_RTSO] = 1'b1;
                state_word[SB_SWON] = 1'b1;
            end
            ST_OPEN, ST_QSA: begin
                state_word[SB_RTSO] = 1'b1;
                state_word[SB_SWON] = 1'b1;
                state_word[SB_OPEN] = 1'b1;
            end
            ST_FRA: begin
                state_word[SB_RTSO] = 1'b1;
                state_word[SB_SWON] = 1'b1;
                state_word[SB_OPEN] = 1'b1;
                state_word[SB_FLT] = 1'b1;
            end
            ST_FLT: state_word[SB_FLT] = 1'b1;
            default: state_word[SB_QS] = 1'b0;
        endcase
        // Only meaningful when the encoder commutates in closed loop
        state_word[SB_IDX] = s_r.index_seen & s_r.cfg[CFG_CLOSED]
                             & s_r.cfg[CFG_ENCCOM];
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    always_comb begin
        setup_ph = psel & ~penable;
        access_ph = psel & penable;
        idx = paddr[PADDR_W-1:2];
        aligned = (paddr[1:0] == WORD_ALIGN);
        hit = 1'b1;
        rd_val = '0;
        unique case (idx)
            IDX_CMD: rd_val[15:0] = s_r.cmd;
            IDX_STAT: rd_val[15:0] = state_word;
            IDX_QSC: rd_val[15:0] = s_r.qs_code;
            IDX_SDC: rd_val[15:0] = s_r.sd_code;
            IDX_MODE: rd_val[7:0] = s_r.mode_req;
            IDX_MACT: rd_val[7:0] = s_r.mode_act;
            IDX_HOLD: rd_val[7:0] = s_r.hold_cfg;
            IDX_IST: rd_val[IRQ_W-1:0] = s_r.irq_st;
            IDX_IMSK: rd_val[IRQ_W-1:0] = s_r.irq_msk;
            IDX_CFG: rd_val[CFG_W-1:0] = s_r.cfg;
            default: hit = 1'b0;
        endcase
        hit = hit & aligned;
        mode_ok = (s_r.st == ST_SOD) | (s_r.st == ST_RTSO) | (s_r.st == ST_SWON);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.stop_now = 1'b0;

        // Read data is captured in setup so prdata comes from a flop
        if (setup_ph) begin
            s_nxt.rdata = hit ? rd_val : RST_RDATA;
            s_nxt.slverr = ~hit;
        end

        if (access_ph && pwrite && hit) begin
            unique case (idx)
                IDX_CMD: s_nxt.cmd = pwdata[15:0];
                IDX_QSC: s_nxt.qs_code = pwdata[15:0];
                IDX_SDC: s_nxt.sd_code = pwdata[15:0];
                IDX_MODE: begin
                    if (mode_ok) begin
                        s_nxt.mode_req = pwdata[7:0];
                    end
                end
                IDX_HOLD: s_nxt.hold_cfg = pwdata[7:0];
                IDX_IMSK: s_nxt.irq_msk = pwdata[IRQ_W-1:0];
                IDX_CFG: s_nxt.cfg = pwdata[CFG_W-1:0];
                default: s_nxt.cmd = s_r.cmd;
            endcase
        end

        // Clear only the bits that the read actually reported
        if (access_ph && !pwrite && hit && idx == IDX_IST) begin
            s_nxt.irq_st = s_r.irq_st & ~s_r.rdata[IRQ_W-1:0];
        end

        s_nxt.index_seen = s_r.index_seen | encoder_index;

        // Power state machine; unmatched commands fall through unchanged
        unique case (s_r.st)
            ST_NRDY: begin
                if (selftest_ok) begin
                    s_nxt.st = ST_SOD;
                end
            end
            ST_SOD: begin
                if (do_shutdown) begin
                    s_nxt.st = ST_RTSO;
                end
            end
            ST_RTSO: begin
                if (s_r.brake_slow) begin
                    if (ramp_done) begin
                        s_nxt.brake_slow = 1'b0;
                        s_nxt.st = ST_SOD;
                    end
                end else if (do_dis_volt || do_quick) begin
                    s_nxt.st = ST_SOD;
                end else if (do_switch_on) begin
                    s_nxt.st = ST_SWON;
                end
            end
            ST_SWON: begin
                if (do_dis_volt || do_quick) begin
                    s_nxt.st = ST_SOD;
                end else if (do_shutdown) begin
                    s_nxt.st = ST_RTSO;
                end else if (do_enable) begin
                    s_nxt.st = ST_OPEN;
                    s_nxt.mode_act = s_r.mode_req;
                end
            end
            ST_OPEN: begin
                if (do_dis_volt) begin
                    s_nxt.st = ST_SOD;
                end else if (do_quick) begin
                    s_nxt.st = ST_QSA;
                    if (s_r.qs_code == RC_SLOW) begin
                        s_nxt.brake_slow = 1'b1;
                    end else if (s_r.qs_code == RC_QUICK) begin
                        s_nxt.brake_quick = 1'b1;
                    end else begin
                        s_nxt.stop_now = 1'b1;
                    end
                end else if (do_shutdown) begin
                    s_nxt.st = ST_RTSO;
                    if (s_r.sd_code == RC_SLOW) begin
                        s_nxt.brake_slow = 1'b1;
                    end else begin
                        s_nxt.stop_now = 1'b1;
                    end
                end else if (do_switch_on) begin
                    s_nxt.st = ST_SWON;
                end
            end
            ST_QSA: begin
                if (do_dis_volt) begin
                    s_nxt.st = ST_SOD;
                    s_nxt.brake_slow = 1'b0;
                    s_nxt.brake_quick = 1'b0;
                end else if (!(s_r.brake_slow || s_r.brake_quick) || ramp_done) begin
                    s_nxt.st = ST_SOD;
                    s_nxt.brake_slow = 1'b0;
                    s_nxt.brake_quick = 1'b0;
                end
            end
            ST_FRA: s_nxt.st = ST_FLT;
            ST_FLT: begin
                if (fault_rise) begin
                    s_nxt.st = ST_SOD;
                end
            end
            ST_DEAD: s_nxt.st = ST_DEAD;
            default: s_nxt.st = ST_NRDY;
        endcase

        if (fault_in && s_r.st != ST_NRDY && s_r.st != ST_DEAD
                && s_r.st != ST_FRA && s_r.st != ST_FLT) begin
            s_nxt.st = ST_FRA;
            s_nxt.brake_slow = 1'b0;
            s_nxt.brake_quick = 1'b0;
            s_nxt.stop_now = 1'b1;
        end

        // No controlword command can leave this lock
        if (fatal_err) begin
            s_nxt.st = ST_DEAD;
            s_nxt.brake_slow = 1'b0;
            s_nxt.brake_quick = 1'b0;
        end

        // Events set after the read clear so a coincident event wins
        if (s_nxt.st != s_r.st) begin
            s_nxt.irq_st[IRQ_STATE] = 1'b1;
        end
        if (s_nxt.st == ST_FRA && s_r.st != ST_FRA) begin
            s_nxt.irq_st[IRQ_FAULT] = 1'b1;
        end
        if (encoder_index && !s_r.index_seen) begin
            s_nxt.irq_st[IRQ_INDEX] = 1'b1;
        end
        if (access_ph && pwrite && hit && idx == IDX_MODE && !mode_ok) begin
            s_nxt.irq_st[IRQ_MODEREJ] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: ST_NRDY, cmd: RST_CMD, qs_code: RST_CODE, sd_code: RST_CODE,
                mode_req: RST_MODE, mode_act: RST_MODE, hold_cfg: RST_HOLD, cfg: RST_CFG,
                irq_st: RST_IRQ, irq_msk: RST_IRQ, rdata: RST_RDATA, default: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_r.rdata;
    assign pready = 1'b1;
    assign pslverr = s_r.slverr & access_ph;
    assign stop_now = s_r.stop_now;
    assign brake_slow = s_r.brake_slow;
    assign brake_quick = s_r.brake_quick;
    assign active_mode = s_r.mode_act;
    assign hold_torque = (s_r.st == ST_SWON) && (s_r.hold_cfg == HOLD_ON);
    // Braking keeps the stage energised until the ramp ends
    assign power_en = (s_r.st == ST_OPEN) | (s_r.st == ST_QSA) | s_r.brake_slow
                      | hold_torque;
    assign irq = |(s_r.irq_st & s_r.irq_msk);

endmodule : dpsm_top

// >>> testbench/dpsm_chk.sv
`timescale 1ns/1ps
module dpsm_chk
    import dpsm_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [PADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic fatal_err, // Unrecoverable error
    input wire logic ramp_done, // Braking finished
    input wire logic stop_now, // Immediate stop
    input wire logic brake_slow, // Slow ramp braking
    input wire logic brake_quick, // Quick ramp braking
    input wire logic power_en, // Power stage on
    input wire logic hold_torque, // Holding torque
    input wire logic [7:0] active_mode // Mode in effect
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    a_ready_const: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_zero_data: assert property (psel && penable && !pwrite && pslverr
        |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    // ------------------------------------------------------------
    // Power and stop reactions
    // ------------------------------------------------------------
    a_mode_on_enable: assert property (!$stable(active_mode) |-> power_en && !hold_torque)
        else $error("active mode changed outside enable");
    a_mode_locked: assert property (psel && penable && pwrite && power_en && !hold_torque
        && paddr == {IDX_MODE, WORD_ALIGN} |=> $stable(active_mode))
        else $error("mode change accepted while running");
    a_stop_pulse: assert property (stop_now |=> !stop_now)
        else $error("stop pulse longer than one cycle");
    a_brake_one: assert property (!(brake_slow && brake_quick))
        else $error("two brake ramps at once");
    a_ramp_end: assert property ((brake_slow || brake_quick) && ramp_done
        |-> ##[1:2] !(brake_slow || brake_quick))
        else $error("braking did not end after ramp");
    a_fatal_off: assert property (fatal_err |-> ##2 (!power_en && !hold_torque)[*8])
        else $error("power after unrecoverable error");
endmodule : dpsm_chk

bind dpsm_top dpsm_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fatal_err(fatal_err), .ramp_done(ramp_done), .stop_now(stop_now),
    .brake_slow(brake_slow), .brake_quick(brake_quick), .power_en(power_en),
    .hold_torque(hold_torque), .active_mode(active_mode));

// >>> testbench/dpsm_motion_mdl.sv
`timescale 1ns/1ps
module dpsm_motion_mdl #(
    parameter int RAMP_LEN = 30
) (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic brake_slow, // Slow ramp requested
    input wire logic brake_quick, // Quick ramp requested
    output logic ramp_done // One pulse when braking ends
);
    int cnt;

    // ------------------------------------------------------------
    // Ramp timer
    // ------------------------------------------------------------
    // Pulse only once per ramp; the drive may drop its request a cycle late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            ramp_done <= 1'b0;
        end else if (brake_slow || brake_quick) begin
            cnt <= cnt + 1;
            ramp_done <= (cnt == RAMP_LEN - 1);
        end else begin
            cnt <= 0;
            ramp_done <= 1'b0;
        end
    end
endmodule : dpsm_motion_mdl

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench
    import dpsm_pkg::*;
;
    localparam int RAMP = 30;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, stop_now, brake_slow, brake_quick, power_en, hold_torque, irq;
    logic selftest_ok = 1'b0, fatal_err = 1'b0, fault_in = 1'b0, encoder_index = 1'b0;
    logic ramp_done;
    logic [7:0] active_mode;
    logic [49:0] exp_q[$];
    logic [49:0] e_cur;
    logic [31:0] seed = 32'h135c_de48;
    logic [7:0] m;
    logic [15:0] defs[8] = '{IDX_CMD, IDX_QSC, IDX_SDC, IDX_MODE, IDX_HOLD, IDX_IMSK,
        IDX_CFG, IDX_MACT};
    int bad_count = 0, samples_checked = 0, stops = 0, n;

    dpsm_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .selftest_ok(selftest_ok), .fatal_err(fatal_err), .fault_in(fault_in),
        .ramp_done(ramp_done), .encoder_index(encoder_index), .stop_now(stop_now),
        .brake_slow(brake_slow), .brake_quick(brake_quick), .power_en(power_en),
        .hold_torque(hold_torque), .active_mode(active_mode), .irq(irq));
    dpsm_motion_mdl #(.RAMP_LEN(RAMP)) u_motion (.clk(clk), .rst(rst),
        .brake_slow(brake_slow), .brake_quick(brake_quick), .ramp_done(ramp_done));

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    // Caller is just past a rising edge; one idle edge follows each transfer
    task automatic xfer(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] ex,
        input logic er);
        seed = lfsr_step(seed);
        exp_q.push_back({w, er, a[17:2], ex});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? ex : seed;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic wr(input logic [15:0] i, input logic [31:0] d);
        xfer(1'b1, {i, WORD_ALIGN}, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [15:0] i, input logic [31:0] ex);
        xfer(1'b0, {i, WORD_ALIGN}, ex, 1'b0);
    endtask : rd

    task automatic cmd(input logic [15:0] c);
        wr(IDX_CMD, {16'h0000, c});
        repeat (3) @(posedge clk);
    endtask : cmd

    task automatic to_open();
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000f);
    endtask : to_open

    task automatic pulse(input int which);
        case (which)
            0: fault_in <= 1'b1;
            1: encoder_index <= 1'b1;
            default: fatal_err <= 1'b1;
        endcase
        @(posedge clk);
        fault_in <= 1'b0;
        encoder_index <= 1'b0;
        fatal_err <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (stop_now === 1'b1) begin
            stops <= stops + 1;
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e_cur = exp_q.pop_front();
            cmp($sformatf("pslverr@%h", e_cur[47:32]), {31'h0, e_cur[48]}, {31'h0, pslverr});
            if (e_cur[49] == 1'b0) begin
                cmp($sformatf("prdata@%h", e_cur[47:32]), e_cur[31:0], prdata);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(IDX_STAT, 32'h0000_0000);
        rd(IDX_IST, 32'h0000_0000);
        foreach (defs[i]) rd(defs[i], 32'h0000_0000);
        selftest_ok <= 1'b1;
        repeat (3) @(posedge clk);
        rd(IDX_STAT, 32'h0000_0060);
        cmp("irq", 32'h0000_0000, {31'h0, irq});
        wr(IDX_IMSK, 32'h0000_000f);
        cmp("irq", 32'h0000_0001, {31'h0, irq});
        rd(IDX_IST, 32'h0000_0001);
        cmp("irq", 32'h0000_0000, {31'h0, irq});
        wr(IDX_STAT, 32'hffff_ffff);
        rd(IDX_STAT, 32'h0000_0060);
        xfer(1'b0, {16'h1234, WORD_ALIGN}, 32'h0000_0000, 1'b1);
        xfer(1'b1, 18'h1_8102, 32'h0000_0000, 1'b1);
        cmd(16'h000f);
        rd(IDX_STAT, 32'h0000_0060);
        cmd(16'h0006);
        rd(IDX_STAT, 32'h0000_0021);
        cmd(16'h0007);
        rd(IDX_STAT, 32'h0000_0023);
        cmp("hold_torque", 32'h0000_0000, {31'h0, hold_torque});
        seed = lfsr_step(seed);
        m = {seed[7:1], 1'b1};
        wr(IDX_MODE, {24'h0, m});
        cmd(16'h000f);
        rd(IDX_STAT, 32'h0000_0037);
        rd(IDX_MACT, {24'h0, m});
        cmp("active_mode", {24'h0, m}, {24'h0, active_mode});
        rd(IDX_IST, 32'h0000_0001);
        wr(IDX_MODE, {24'h0, ~m});
        rd(IDX_IST, 32'h0000_0008);
        rd(IDX_MODE, {24'h0, m});
        cmd(16'h0007);
        rd(IDX_STAT, 32'h0000_0023);
        wr(IDX_HOLD, 32'h0000_0001);
        rd(IDX_STAT, 32'h0000_0033);
        cmp("hold_torque", 32'h0000_0001, {31'h0, hold_torque});
        wr(IDX_HOLD, 32'h0000_0000);
        cmd(16'h000d);
        rd(IDX_STAT, 32'h0000_0060);
        // Code 3 is reserved and must behave as an immediate stop
        for (int c = 0; c < 4; c++) begin
            wr(IDX_QSC, 32'(c));
            to_open();
            n = stops;
            cmd(16'h000b);
            if (c == 1 || c == 2) begin
                cmp("brake_slow", 32'(c == 1), {31'h0, brake_slow});
                cmp("brake_quick", 32'(c == 2), {31'h0, brake_quick});
                rd(IDX_STAT, 32'h0000_0017);
                repeat (RAMP + 8) @(posedge clk);
            end else begin
                cmp("stop_now", 32'(n + 1), 32'(stops));
            end
            rd(IDX_STAT, 32'h0000_0060);
        end
        // A held shutdown fires again once back in the disabled state
        for (int c = 0; c < 2; c++) begin
            wr(IDX_SDC, 32'(c));
            to_open();
            n = stops;
            cmd(16'h0006);
            if (c == 1) begin
                cmp("brake_slow", 32'h0000_0001, {31'h0, brake_slow});
                rd(IDX_STAT, 32'h0000_0031);
                repeat (RAMP + 8) @(posedge clk);
            end else begin
                cmp("stop_now", 32'(n + 1), 32'(stops));
            end
            rd(IDX_STAT, 32'h0000_0021);
        end
        to_open();
        pulse(0);
        rd(IDX_STAT, 32'h0000_0028);
        cmd(16'h0080);
        rd(IDX_STAT, 32'h0000_0060);
        pulse(0);
        rd(IDX_STAT, 32'h0000_0028);
        cmd(16'h0000);
        cmd(16'h0080);
        rd(IDX_STAT, 32'h0000_0060);
        pulse(1);
        rd(IDX_STAT, 32'h0000_0060);
        wr(IDX_CFG, 32'h0000_0003);
        rd(IDX_STAT, 32'h0000_8060);
        wr(IDX_CFG, 32'h0000_0000);
        pulse(2);
        rd(IDX_STAT, 32'h0000_0000);
        cmd(16'h0006);
        rd(IDX_STAT, 32'h0000_0000);
        wrap_up();
    end
endmodule : testbench
